// *** design/pbx_pins.sv ***
`timescale 1ns/1ns


module pbx_pins (
  // Clock, reset, enable
  input  wire logic               i_mclk,
  input  wire logic               i_arst_n,
  input  wire logic               i_ce,
  // Reset pin, fetch strap, lock and latch-pulse control
  input  wire logic               i_rst_pin,
  input  wire logic               i_external_fetch_select_n,
  input  wire logic               i_lock_bit1,
  input  wire logic               i_ale_disable,
  // Flash programming and verification
  input  wire logic               i_flash_flash_write_pulse,
  input  wire logic               i_flash_verify,
  input  wire logic [7:0]         i_verify_byte,
  output logic                    o_flash_write_pulse,
  output logic [7:0]              o_flash_byte,
  // Core side: latch writes, data moves, code fetches
  input  pbx_pkg::pbx_port_wr_t   i_port_wr,
  input  pbx_pkg::pbx_xreq_t      i_xreq,
  input  wire logic               i_code_table_read,
  input  wire logic [15:0]        i_fetch_addr,
  output logic                    o_dev_reset,
  output logic                    o_ext_exec,
  output logic                    o_xdone,
  output logic [7:0]              o_xrdata,
  output logic [7:0]              o_code_byte,
  output logic                    o_code_valid,
  output pbx_pkg::pbx_pins_t      o_pin_levels,
  // Alternate functions
  input  wire logic               i_serial_tx,
  input  wire logic               i_clkout_en,
  input  wire logic               i_clkout,
  output pbx_pkg::pbx_alt_in_t    o_alt_in,
  // Address/data port pins
  input  wire logic [7:0]         i_addr_data_port,
  output logic [7:0]              o_addr_data_port,
  output logic [7:0]              o_addr_data_port_oe,
  // General port pins
  input  wire logic [7:0]         i_general_port_a,
  output logic [7:0]              o_general_port_a,
  output logic [7:0]              o_general_port_a_oe,
  // High address port pins
  input  wire logic [7:0]         i_high_addr_port,
  output logic [7:0]              o_high_addr_port,
  output logic [7:0]              o_high_addr_port_oe,
  // Special function port pins
  input  wire logic [7:0]         i_special_function_port,
  output logic [7:0]              o_special_function_port,
  output logic [7:0]              o_special_function_port_oe,
  // Latch pulse pin and code read strobe
  input  wire logic               i_ale,
  output logic                    o_ale,
  output logic                    o_ale_oe,
  output logic                    o_code_read_strobe_n
);

  // Next code address for the second fetch of a cycle
  function automatic logic [15:0] next_addr(input logic [15:0] a);
    next_addr = a + 16'h0001;
  endfunction

  // Quasi-bidirectional drive: strong low only, ones left to the pullup
  function automatic logic [7:0] quasi_oe(input logic [7:0] v);
    quasi_oe = ~v;
  endfunction

  // Phase lies in [lo, lo+len)
  function automatic logic in_window(input logic [3:0] ph, input logic [3:0] lo,
                                     input logic [3:0] len);
    in_window = (ph >= lo) && (ph < lo + len);
  endfunction

  pbx_pkg::pbx_state_t st_q, st_d;
  logic [3:0]  phase;
  logic        mc_last;
  logic [4:0]  rst_cnt_q, rst_cnt_d;
  logic        dev_rst_q, dev_rst_d;
  logic        fetch_strap_q;
  logic        strap_catch;
  logic [7:0]  lat_ad_q, lat_gpa_q, lat_ha_q, lat_sfp_q;

  // Reset pin qualification: two full machine cycles of high level
  assign rst_cnt_d = !i_rst_pin ? 5'h00
                   : (rst_cnt_q == pbx_pkg::RST_HOLD_CLKS) ? rst_cnt_q
                   : rst_cnt_q + 5'h01;
  // Once in reset, stay there until the pin is seen low
  assign dev_rst_d = i_rst_pin && (dev_rst_q || rst_cnt_d == pbx_pkg::RST_HOLD_CLKS);
  assign strap_catch = dev_rst_q && !i_rst_pin;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_cnt_q <= 5'h00;
      dev_rst_q <= 1'b1;
    end else if (i_ce) begin
      rst_cnt_q <= rst_cnt_d;
      dev_rst_q <= dev_rst_d;
    end
  end

  // Fetch strap caught at reset release; only used when lock bit 1 is set
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fetch_strap_q <= 1'b0;
    end else if (i_ce && strap_catch) begin
      fetch_strap_q <= !i_external_fetch_select_n;
    end
  end

  // Board strap low selects external code, latched copy wins when locked
  logic ext_exec;
  assign ext_exec = i_lock_bit1 ? fetch_strap_q : !i_external_fetch_select_n;

  // Machine-cycle phase generator, restarted while the device is in reset
  pbx_phase u_phase (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .i_sync   (dev_rst_q),
    .o_phase  (phase),
    .o_last   (mc_last)
  );

  // Bus sequencer: data moves start only on a machine-cycle boundary
  always_comb begin
    st_d = st_q;
    case (st_q)
      pbx_pkg::ST_RESET: begin
        if (!dev_rst_q) st_d = pbx_pkg::ST_FETCH;
      end
      pbx_pkg::ST_FETCH: begin
        if (mc_last && i_xreq.valid) st_d = pbx_pkg::ST_XDATA;
      end
      pbx_pkg::ST_XDATA: begin
        if (mc_last) st_d = pbx_pkg::ST_FETCH;
      end
      default: st_d = pbx_pkg::ST_RESET;
    endcase
    if (dev_rst_q) st_d = pbx_pkg::ST_RESET;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= pbx_pkg::ST_RESET;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  // Port latches, all ones after reset so every pin floats or pulls high
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lat_ad_q  <= pbx_pkg::LATCH_RST;
      lat_gpa_q <= pbx_pkg::LATCH_RST;
      lat_ha_q  <= pbx_pkg::LATCH_RST;
      lat_sfp_q <= pbx_pkg::LATCH_RST;
    end else if (i_ce) begin
      if (dev_rst_q) begin
        lat_ad_q  <= pbx_pkg::LATCH_RST;
        lat_gpa_q <= pbx_pkg::LATCH_RST;
        lat_ha_q  <= pbx_pkg::LATCH_RST;
        lat_sfp_q <= pbx_pkg::LATCH_RST;
      end else begin
        if (i_port_wr.we[pbx_pkg::PSEL_AD])  lat_ad_q  <= i_port_wr.data;
        if (i_port_wr.we[pbx_pkg::PSEL_GPA]) lat_gpa_q <= i_port_wr.data;
        if (i_port_wr.we[pbx_pkg::PSEL_HA])  lat_ha_q  <= i_port_wr.data;
        if (i_port_wr.we[pbx_pkg::PSEL_SFP]) lat_sfp_q <= i_port_wr.data;
      end
    end
  end

  // Cycle decode
  logic in_fetch, in_xdata, bus_on, second_half;
  logic addr_ph, ale_ph, code_read_strobe_ph, xstr_ph, code_cap, xrd_cap;
  logic [15:0] cur_addr;
  assign in_fetch    = (st_q == pbx_pkg::ST_FETCH);
  assign in_xdata    = (st_q == pbx_pkg::ST_XDATA);
  assign bus_on      = in_xdata || (in_fetch && ext_exec);
  assign second_half = (phase >= pbx_pkg::PH_ALE_B);
  assign addr_ph     = in_window(phase, pbx_pkg::PH_ALE_A, pbx_pkg::PH_ADDR_W)
                    || (in_fetch && in_window(phase, pbx_pkg::PH_ALE_B, pbx_pkg::PH_ADDR_W));
  assign ale_ph      = (phase == pbx_pkg::PH_ALE_A) || (phase == pbx_pkg::PH_ALE_A + 4'h1)
                    || (phase == pbx_pkg::PH_ALE_B) || (phase == pbx_pkg::PH_ALE_B + 4'h1);
  assign code_read_strobe_ph     = in_window(phase, pbx_pkg::PH_CODE_A - 4'h2, pbx_pkg::PH_STR_LEN)
                    || in_window(phase, pbx_pkg::PH_CODE_B - 4'h2, pbx_pkg::PH_STR_LEN);
  assign xstr_ph     = (phase >= pbx_pkg::PH_XSTR_LO) && (phase <= pbx_pkg::PH_XSTR_HI);
  assign code_cap    = in_fetch && ext_exec
                    && (phase == pbx_pkg::PH_CODE_A || phase == pbx_pkg::PH_CODE_B);
  assign xrd_cap     = in_xdata && !i_xreq.write && (phase == pbx_pkg::PH_XRD_CAP);
  assign cur_addr    = in_xdata ? i_xreq.addr
                     : (second_half ? next_addr(i_fetch_addr) : i_fetch_addr);

  // Address/data port drive
  logic [7:0] ad_d, ad_oe_d;
  assign ad_d = i_flash_verify ? i_verify_byte
              : i_flash_flash_write_pulse ? pbx_pkg::BYTE_ONES
              : (bus_on && addr_ph) ? cur_addr[7:0]
              : (in_xdata && i_xreq.write && !addr_ph) ? i_xreq.wdata
              : bus_on ? pbx_pkg::BYTE_ONES
              : lat_ad_q;
  // Verification leans on outside pullups, so it drives lows only
  assign ad_oe_d = i_flash_verify ? ~i_verify_byte
                 : i_flash_flash_write_pulse ? pbx_pkg::BYTE_ZERO
                 : (bus_on && addr_ph) ? pbx_pkg::BYTE_ONES
                 : (in_xdata && i_xreq.write && !addr_ph) ? pbx_pkg::BYTE_ONES
                 : bus_on ? pbx_pkg::BYTE_ZERO
                 : ~lat_ad_q;

  // High address port: address on external fetches and wide moves, latch otherwise
  logic       ha_addr;
  logic [7:0] ha_d, ha_oe_d;
  // Covers the whole external fetch cycle around each code strobe, so a strobe never meets a quasi high byte
  assign ha_addr = (in_fetch && ext_exec) || (in_xdata && i_xreq.wide);
  assign ha_d    = ha_addr ? cur_addr[15:8] : lat_ha_q;
  assign ha_oe_d = ha_addr ? pbx_pkg::BYTE_ONES : quasi_oe(lat_ha_q);

  // General port: bit 0 may carry the timer-two clock out
  logic [7:0] gpa_d;
  assign gpa_d = {lat_gpa_q[7:1],
                  lat_gpa_q[pbx_pkg::GPA_CNT2] & (!i_clkout_en || i_clkout)};

  // Special function port: transmit and data strobes AND into the latch
  logic       xwr_n, xrd_n;
  logic [7:0] sfp_d;
  assign xwr_n = !(in_xdata && i_xreq.write && xstr_ph);
  assign xrd_n = !(in_xdata && !i_xreq.write && xstr_ph);
  always_comb begin
    sfp_d = lat_sfp_q;
    sfp_d[pbx_pkg::SFP_TXD] = lat_sfp_q[pbx_pkg::SFP_TXD] & i_serial_tx;
    sfp_d[pbx_pkg::SFP_WR]  = lat_sfp_q[pbx_pkg::SFP_WR] & xwr_n;
    sfp_d[pbx_pkg::SFP_RD]  = lat_sfp_q[pbx_pkg::SFP_RD] & xrd_n;
  end

  // Latch pulse: free running unless disabled, one pulse lost per data move
  logic ale_en, ale_d, ale_oe_d, code_read_strobe_n_d;
  assign ale_en = ext_exec || !i_ale_disable || in_xdata || i_code_table_read;
  assign ale_d  = !ale_en ? 1'b1
                : (ale_ph && !(in_xdata && second_half) && !dev_rst_q);
  // The weak pullup holds the pin high when the pulse is off
  assign ale_oe_d = !i_flash_flash_write_pulse && ale_en;

  // Code read strobe twice a cycle, both skipped in a data move
  assign code_read_strobe_n_d = !(in_fetch && ext_exec && code_read_strobe_ph);

  // Pin-facing outputs, all registered
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_addr_data_port           <= pbx_pkg::LATCH_RST;
      o_addr_data_port_oe        <= pbx_pkg::BYTE_ZERO;
      o_general_port_a           <= pbx_pkg::LATCH_RST;
      o_general_port_a_oe        <= pbx_pkg::BYTE_ZERO;
      o_high_addr_port           <= pbx_pkg::LATCH_RST;
      o_high_addr_port_oe        <= pbx_pkg::BYTE_ZERO;
      o_special_function_port    <= pbx_pkg::LATCH_RST;
      o_special_function_port_oe <= pbx_pkg::BYTE_ZERO;
      o_ale                      <= 1'b1;
      o_ale_oe                   <= 1'b0;
      o_code_read_strobe_n       <= 1'b1;
    end else if (i_ce) begin
      o_addr_data_port           <= ad_d;
      o_addr_data_port_oe        <= ad_oe_d;
      o_general_port_a           <= gpa_d;
      o_general_port_a_oe        <= quasi_oe(gpa_d);
      o_high_addr_port           <= ha_d;
      o_high_addr_port_oe        <= ha_oe_d;
      o_special_function_port    <= sfp_d;
      o_special_function_port_oe <= quasi_oe(sfp_d);
      o_ale                      <= ale_d;
      o_ale_oe                   <= ale_oe_d;
      o_code_read_strobe_n       <= code_read_strobe_n_d;
    end
  end

  // Core-facing results and pin readback
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dev_reset         <= 1'b1;
      o_ext_exec          <= 1'b0;
      o_xdone             <= 1'b0;
      o_xrdata            <= pbx_pkg::BYTE_ZERO;
      o_code_byte         <= pbx_pkg::BYTE_ZERO;
      o_code_valid        <= 1'b0;
      o_pin_levels        <= '1;
      o_alt_in            <= '1;
      o_flash_write_pulse <= 1'b1;
      o_flash_byte        <= pbx_pkg::BYTE_ZERO;
    end else if (i_ce) begin
      o_dev_reset  <= dev_rst_q;
      o_ext_exec   <= ext_exec;
      o_xdone      <= in_xdata && mc_last;
      o_code_valid <= code_cap;
      if (xrd_cap) o_xrdata <= i_addr_data_port;
      if (code_cap) o_code_byte <= i_addr_data_port;
      o_pin_levels <= {i_special_function_port, i_high_addr_port,
                       i_general_port_a, i_addr_data_port};
      o_alt_in <= {i_special_function_port[pbx_pkg::SFP_RXD],
                   i_special_function_port[pbx_pkg::SFP_IRQ0],
                   i_special_function_port[pbx_pkg::SFP_IRQ1],
                   i_special_function_port[pbx_pkg::SFP_CNT0],
                   i_special_function_port[pbx_pkg::SFP_CNT1],
                   i_general_port_a[pbx_pkg::GPA_CNT2],
                   i_general_port_a[pbx_pkg::GPA_TRG2]};
      // Program pulse is only taken while programming; idle high otherwise
      o_flash_write_pulse <= i_flash_flash_write_pulse ? i_ale : 1'b1;
      if (i_flash_flash_write_pulse) o_flash_byte <= i_addr_data_port;
    end
  end

endmodule

// *** design/pbx_pkg.sv ***
package pbx_pkg;

  // Port geometry and reset contents of every port latch
  localparam int         PORT_W      = 8;
  localparam logic [7:0] LATCH_RST   = 8'hFF;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [7:0] BYTE_ONES   = 8'hFF;

  // Oscillator and machine-cycle timing
  localparam int         OSC_PERIOD_NS = 100;
  localparam int         OSC_PER_MC    = 12;
  localparam int         MC_NS         = OSC_PERIOD_NS * OSC_PER_MC;
  localparam int         RST_HOLD_MC   = 2;
  localparam int         RST_HOLD_NS   = RST_HOLD_MC * MC_NS;
  localparam logic [4:0] RST_HOLD_CLKS = 5'((RST_HOLD_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS);

  // Phases within one machine cycle (0 .. 11)
  localparam logic [3:0] PH_FIRST   = 4'h0;
  localparam logic [3:0] PH_LAST    = 4'hB;
  localparam logic [3:0] PH_ALE_A   = 4'h0;
  localparam logic [3:0] PH_ALE_B   = 4'h6;
  localparam logic [3:0] PH_ADDR_W  = 4'h3;
  localparam logic [3:0] PH_STR_LEN = 4'h3;
  localparam logic [3:0] PH_CODE_A  = 4'h5;
  localparam logic [3:0] PH_CODE_B  = 4'hB;
  localparam logic [3:0] PH_XSTR_LO = 4'h3;
  localparam logic [3:0] PH_XSTR_HI = 4'hA;
  localparam logic [3:0] PH_XRD_CAP = 4'hA;

  // Special register that holds the latch-pulse disable bit
  localparam logic [7:0] ALE_CTRL_ADDR = 8'h8E;
  localparam int         ALE_DIS_BIT   = 0;

  // Special-function port and general port bit positions
  localparam int SFP_RXD  = 0;
  localparam int SFP_TXD  = 1;
  localparam int SFP_IRQ0 = 2;
  localparam int SFP_IRQ1 = 3;
  localparam int SFP_CNT0 = 4;
  localparam int SFP_CNT1 = 5;
  localparam int SFP_WR   = 6;
  localparam int SFP_RD   = 7;
  localparam int GPA_CNT2 = 0;
  localparam int GPA_TRG2 = 1;

  // Port select bits of a latch write
  localparam int PSEL_AD  = 0;
  localparam int PSEL_GPA = 1;
  localparam int PSEL_HA  = 2;
  localparam int PSEL_SFP = 3;

  // Bus sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_FETCH = 3'b010,
    ST_XDATA = 3'b100
  } pbx_state_t;

  // Core write into the port latches
  typedef struct packed {
    logic [3:0] we;
    logic [7:0] data;
  } pbx_port_wr_t;

  // External data move request from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pbx_xreq_t;

  // Alternate-function inputs seen on the pins
  typedef struct packed {
    logic serial_rx;
    logic ext_irq_zero;
    logic ext_irq_one;
    logic counter_zero_input;
    logic counter_one_input;
    logic count_in_timer_two;
    logic timer_two_trigger_input;
  } pbx_alt_in_t;

  // Pin levels of all four ports as read back
  typedef struct packed {
    logic [7:0] special_function_port;
    logic [7:0] high_addr_port;
    logic [7:0] general_port_a;
    logic [7:0] addr_data_port;
  } pbx_pins_t;

endpackage

// *** design/pbx_phase.sv ***
`timescale 1ns/1ns

module pbx_phase (
  // Clock, reset, enable
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic       i_ce,
  // Restart the cycle
  input  wire logic       i_sync,
  // Phase state
  output logic [3:0]      o_phase,
  output logic            o_last
);

  logic [3:0] phase_q;
  logic [3:0] phase_d;

  // Twelve oscillator periods make one machine cycle
  assign phase_d = (i_sync || phase_q == pbx_pkg::PH_LAST) ? pbx_pkg::PH_FIRST
                                                          : phase_q + 4'h1;
  assign o_phase = phase_q;
  assign o_last  = (phase_q == pbx_pkg::PH_LAST);

  // Phase counter, frozen while the enable is low
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_q <= pbx_pkg::PH_FIRST;
    end else if (i_ce) begin
      phase_q <= phase_d;
    end
  end

endmodule

// *** tb/pbx_pins_properties.sv ***
`timescale 1ns/1ns

module pbx_pins_chk (
  // Clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_arst_n,
  // Control inputs
  input  wire logic          i_rst_pin,
  input  wire logic          i_ale_disable,
  input  wire logic          i_flash_flash_write_pulse,
  input  wire logic          i_code_table_read,
  input  wire logic          i_ale,
  input  pbx_pkg::pbx_xreq_t i_xreq,
  // Watched outputs
  input  wire logic          o_dev_reset,
  input  wire logic          o_ext_exec,
  input  wire logic          o_ale,
  input  wire logic          o_ale_oe,
  input  wire logic          o_code_read_strobe_n,
  input  wire logic          o_flash_write_pulse,
  input  wire logic [7:0]    o_high_addr_port_oe,
  input  wire logic [7:0]    o_special_function_port,
  input  wire logic [7:0]    o_special_function_port_oe
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  logic [4:0] rst_run_q;
  logic       dstb;

  // Data strobe seen on the pins; a latch write of zero there would look the same
  assign dstb = |(~o_special_function_port[7:6] & o_special_function_port_oe[7:6]);

  // Consecutive samples of the reset pin held high, saturating
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) rst_run_q <= 5'h00;
    else rst_run_q <= !i_rst_pin ? 5'h00 : (rst_run_q == 5'h1F ? rst_run_q : rst_run_q + 5'h01);
  end

  a_dev_reset_hold: assert property ($rose(o_dev_reset) |-> rst_run_q >= 5'd24)
    else $error("device reset after a short reset pin");
  a_ale_width: assert property ($rose(o_ale) && o_ale_oe
    |=> (o_ale || o_dev_reset) ##1 !(o_ale && o_ale_oe)) else $error("latch pulse width wrong");
  a_ale_period: assert property ($rose(o_ale) && o_ale_oe && !i_ale_disable
    |-> ##6 (o_ale || dstb || o_dev_reset)) else $error("latch pulse missing at sixth clock");
  a_strobe_width: assert property ($fell(o_code_read_strobe_n)
    |-> !o_code_read_strobe_n [*3] ##1 o_code_read_strobe_n) else $error("code strobe width");
  a_strobe_rate: assert property ($fell(o_code_read_strobe_n)
    |-> ##6 (!o_code_read_strobe_n || dstb || o_dev_reset)) else $error("code strobe missing");
  a_move_quiet: assert property (dstb |-> o_code_read_strobe_n && !(o_ale && o_ale_oe))
    else $error("strobe or latch pulse inside data move");
  a_fetch_high_addr: assert property (!o_code_read_strobe_n |-> o_high_addr_port_oe == 8'hFF)
    else $error("high address not driven in fetch");
  a_flash_write_pulse_pulse_in: assert property (i_flash_flash_write_pulse
    |=> !o_ale_oe && o_flash_write_pulse == $past(i_ale)) else $error("program pulse path");
  a_ext_ale_kept: assert property (o_ext_exec && !o_dev_reset && !$past(o_dev_reset)
    && !i_flash_flash_write_pulse && !$past(i_flash_flash_write_pulse) |-> o_ale_oe) else $error("latch pin released");
  a_ale_off_idle: assert property ((i_ale_disable && !o_ext_exec && !i_xreq.valid
    && !i_code_table_read) [*8] |-> !(o_ale && o_ale_oe)) else $error("latch pulse when disabled");
endmodule

bind pbx_pins pbx_pins_chk u_chk (.i_mclk, .i_arst_n, .i_rst_pin, .i_ale_disable, .i_flash_flash_write_pulse,
  .i_code_table_read, .i_ale, .i_xreq, .o_dev_reset, .o_ext_exec, .o_ale, .o_ale_oe,
  .o_code_read_strobe_n, .o_flash_write_pulse, .o_high_addr_port_oe, .o_special_function_port,
  .o_special_function_port_oe);

// *** tb/pbx_mem_model.sv ***
`timescale 1ns/1ns

module pbx_mem_model (
  // Clock and pins seen by the memory
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_ad_out,
  input  wire logic [7:0] i_ad_oe,
  input  wire logic [7:0] i_high,
  input  wire logic       i_ale,
  input  wire logic       i_code_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_rd_n,
  // Resolved address/data pins
  output logic [7:0]      o_ad_pin
);
  logic [7:0] lo_q;
  logic [7:0] drv;
  bit   [7:0] mem [0:65535];

  // Address latch follows the bus while the pulse is high; writes land at the strobe
  always @(posedge i_mclk) begin
    if (i_ale) lo_q <= o_ad_pin;
    if (!i_wr_n) mem[{i_high, lo_q}] <= o_ad_pin;
  end

  // Code bytes depend on the high byte only; a released bus floats to the pullup level
  always @* begin
    if (!i_code_rd_n) drv = i_high ^ 8'h5A;
    else if (!i_rd_n) drv = mem[{i_high, lo_q}];
    else drv = 8'hFF;
    o_ad_pin = (i_ad_out & i_ad_oe) | (drv & ~i_ad_oe);
  end
endmodule

// *** tb/pbx_pins_test.sv ***
`timescale 1ns/1ns

module pbx_pins_test;
  logic i_mclk, i_arst_n, i_ce, i_rst_pin, i_external_fetch_select_n, i_lock_bit1;
  logic i_ale_disable, i_flash_flash_write_pulse, i_flash_verify, i_code_table_read, i_ale, flash_write_pulse_pulse;
  logic i_serial_tx, i_clkout_en, i_clkout, o_flash_write_pulse, o_dev_reset, o_ext_exec;
  logic o_xdone, o_code_valid, o_ale, o_ale_oe, o_code_read_strobe_n, ale_prev, strb_prev;
  logic [7:0] i_verify_byte, o_flash_byte, o_xrdata, o_code_byte, gpa_ext, sfp_ext;
  logic [15:0] i_fetch_addr;
  logic [7:0] i_addr_data_port, o_addr_data_port, o_addr_data_port_oe;
  logic [7:0] i_general_port_a, o_general_port_a, o_general_port_a_oe;
  logic [7:0] i_high_addr_port, o_high_addr_port, o_high_addr_port_oe;
  logic [7:0] i_special_function_port, o_special_function_port, o_special_function_port_oe;
  pbx_pkg::pbx_port_wr_t i_port_wr;
  pbx_pkg::pbx_xreq_t    i_xreq;
  pbx_pkg::pbx_pins_t    o_pin_levels;
  pbx_pkg::pbx_alt_in_t  o_alt_in;
  int err_count, checks_done, ale_cnt, strb_cnt;

  // Quasi ports: pullup unless driven low by the device or, on the general and special ports, held low from outside
  assign i_general_port_a = ((o_general_port_a & o_general_port_a_oe) | ~o_general_port_a_oe)
    & gpa_ext;
  assign i_high_addr_port = (o_high_addr_port & o_high_addr_port_oe) | ~o_high_addr_port_oe;
  assign i_special_function_port = ((o_special_function_port & o_special_function_port_oe)
    | ~o_special_function_port_oe) & sfp_ext;
  assign i_ale = i_flash_flash_write_pulse ? flash_write_pulse_pulse : (o_ale_oe ? o_ale : 1'b1);

  pbx_pins dut (.i_mclk, .i_arst_n, .i_ce, .i_rst_pin, .i_external_fetch_select_n, .i_lock_bit1,
    .i_ale_disable, .i_flash_flash_write_pulse, .i_flash_verify, .i_verify_byte, .o_flash_write_pulse,
    .o_flash_byte, .i_port_wr, .i_xreq, .i_code_table_read, .i_fetch_addr, .o_dev_reset,
    .o_ext_exec, .o_xdone, .o_xrdata, .o_code_byte, .o_code_valid, .o_pin_levels, .i_serial_tx,
    .i_clkout_en, .i_clkout, .o_alt_in, .i_addr_data_port, .o_addr_data_port,
    .o_addr_data_port_oe, .i_general_port_a, .o_general_port_a, .o_general_port_a_oe,
    .i_high_addr_port, .o_high_addr_port, .o_high_addr_port_oe, .i_special_function_port,
    .o_special_function_port, .o_special_function_port_oe, .i_ale, .o_ale, .o_ale_oe,
    .o_code_read_strobe_n);

  pbx_mem_model u_mem (.i_mclk, .i_ad_out(o_addr_data_port), .i_ad_oe(o_addr_data_port_oe),
    .i_high(i_high_addr_port), .i_ale, .i_code_rd_n(o_code_read_strobe_n),
    .i_wr_n(i_special_function_port[6]), .i_rd_n(i_special_function_port[7]),
    .o_ad_pin(i_addr_data_port));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // Latch pulses and code strobes counted on the settled half of the clock
  always @(negedge i_mclk) begin
    if (o_ale && o_ale_oe && !ale_prev) ale_cnt++;
    if (!o_code_read_strobe_n && strb_prev) strb_cnt++;
    ale_prev = o_ale && o_ale_oe;
    strb_prev = o_code_read_strobe_n;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic port_wr(input logic [3:0] we, input logic [7:0] d);
    i_port_wr <= '{we: we, data: d};
    @(posedge i_mclk);
    i_port_wr <= '0;
    cyc(3);
  endtask

  // Request held until the done pulse is seen, then dropped on the next edge
  task automatic move(input logic wr, input logic wide, input logic [15:0] a, input logic [7:0] d);
    int k;
    i_xreq <= '{valid: 1'b1, write: wr, wide: wide, addr: a, wdata: d};
    for (k = 0; k < 40 && o_xdone !== 1'b1; k++) @(negedge i_mclk);
    if (o_xdone !== 1'b1) check(8'h00, 8'h01);
    if (o_xdone !== 1'b1) print_verdict;
    @(posedge i_mclk);
    i_xreq.valid <= 1'b0;
    cyc(1);
  endtask

  task automatic dev_reset_pulse;
    int k;
    i_rst_pin <= 1'b1;
    cyc(30);
    i_rst_pin <= 1'b0;
    for (k = 0; k < 50 && o_dev_reset !== 1'b0; k++) @(negedge i_mclk);
    if (o_dev_reset !== 1'b0) check(8'h00, 8'h01);
    if (o_dev_reset !== 1'b0) print_verdict;
    cyc(2);
  endtask

  // Ten machine cycles, optionally with one data move inside
  task automatic window(input bit mv, input logic [7:0] exp_ale, input logic [7:0] exp_strb);
    // Let a just-changed setting reach the pins before counting starts
    cyc(2);
    ale_cnt = 0;
    strb_cnt = 0;
    fork
      cyc(120);
      if (mv) begin
        cyc(30);
        move(1'b1, 1'b1, 16'h5501, 8'h33);
      end
    join
    check(8'(ale_cnt), exp_ale);
    check(8'(strb_cnt), exp_strb);
  endtask

  initial begin
    {i_arst_n, i_rst_pin, i_ce, i_external_fetch_select_n, i_lock_bit1} = 5'b01110;
    {i_ale_disable, i_flash_flash_write_pulse, i_flash_verify, i_code_table_read, flash_write_pulse_pulse} = 5'b00001;
    {i_serial_tx, i_clkout_en, i_clkout, ale_prev, strb_prev} = 5'b10001;
    {i_verify_byte, gpa_ext, sfp_ext, i_fetch_addr} = {8'h00, 8'hFF, 8'hFF, 16'h1234};
    i_port_wr = '0;
    i_xreq = '0;
    cyc(10);
    @(negedge i_mclk);
    check(o_addr_data_port_oe, 8'h00);
    check({o_ale_oe, o_code_read_strobe_n, o_dev_reset}, 8'h03);
    @(posedge i_mclk);
    i_arst_n <= 1'b1;
    dev_reset_pulse();
    check(o_ext_exec, 1'b0);
    window(1'b0, 8'd20, 8'd0);
    port_wr(4'h1, 8'h0F);
    check(o_addr_data_port_oe, 8'hF0);
    port_wr(4'h1, 8'hFF);
    check(o_addr_data_port_oe, 8'h00);
    gpa_ext <= 8'hFE;
    port_wr(4'h2, 8'h5A);
    check(o_general_port_a_oe, 8'hA5);
    check(o_pin_levels.general_port_a, 8'h5A);
    check({o_alt_in.count_in_timer_two, o_alt_in.timer_two_trigger_input}, 8'h01);
    sfp_ext <= 8'hC3;
    i_serial_tx <= 1'b0;
    cyc(3);
    check({o_alt_in.serial_rx, o_alt_in.ext_irq_zero, o_alt_in.ext_irq_one}, 8'h04);
    check({o_alt_in.counter_zero_input, o_alt_in.counter_one_input}, 8'h00);
    check(o_special_function_port_oe[1], 1'b1);
    {sfp_ext, i_serial_tx} <= 9'h1FF;
    port_wr(4'h4, 8'h3C);
    move(1'b1, 1'b0, 16'h0077, 8'h96);
    move(1'b0, 1'b1, 16'h3C77, 8'h00);
    check(o_xrdata, 8'h96);
    move(1'b1, 1'b1, 16'hAB12, 8'h4D);
    port_wr(4'h4, 8'hAB);
    move(1'b0, 1'b0, 16'h0012, 8'h00);
    check(o_xrdata, 8'h4D);
    window(1'b1, 8'd19, 8'd0);
    i_ale_disable <= 1'b1;
    window(1'b0, 8'd0, 8'd0);
    window(1'b1, 8'd1, 8'd0);
    i_code_table_read <= 1'b1;
    window(1'b0, 8'd20, 8'd0);
    {i_code_table_read, i_external_fetch_select_n, i_lock_bit1} <= 3'b001;
    dev_reset_pulse();
    check(o_ext_exec, 1'b1);
    i_external_fetch_select_n <= 1'b1;
    cyc(5);
    check(o_ext_exec, 1'b1);
    window(1'b0, 8'd20, 8'd20);
    @(negedge i_mclk);
    for (int k = 0; k < 20 && o_code_valid !== 1'b1; k++) @(negedge i_mclk);
    check(o_code_valid, 1'b1);
    check(o_code_byte, 8'h48);
    window(1'b1, 8'd19, 8'd18);
    {i_flash_flash_write_pulse, flash_write_pulse_pulse} <= 2'b10;
    cyc(3);
    check({o_ale_oe, o_flash_write_pulse}, 8'h00);
    {i_flash_flash_write_pulse, i_flash_verify, i_verify_byte} <= {2'b01, 8'hA5};
    cyc(3);
    check(o_addr_data_port_oe, 8'h5A);
    print_verdict();
  end
endmodule
